// [rtl/adm_pkg.sv]
package adm_pkg;

  // Pin widths
  localparam int ADM_AD_WIDTH   = 16;
  localparam int ADM_ADDR_WIDTH = 24;

  // Flag redirection: both pin bytes swap places
  localparam int ADM_FLAG_BYTE_SHIFT = 8;

  // Bus cycle phase lengths in core clock cycles
  localparam logic [3:0] ADM_ADDR_CYCLES   = 4'h2;
  localparam logic [3:0] ADM_STROBE_CYCLES = 4'h4;
  localparam logic [3:0] ADM_HOLD_CYCLES   = 4'h1;

  // Straps settle through the synchroniser before they are captured
  localparam logic [1:0] ADM_STRAP_SETTLE = 2'h2;

  // Multiplier lock wait after reset, in reference clock cycles
  localparam int ADM_LOCK_REF_CYCLES = 4096;

  // Core-to-reference ratios selected by the clock ratio straps
  localparam logic [4:0] ADM_RATIO_3  = 5'h03;
  localparam logic [4:0] ADM_RATIO_16 = 5'h10;
  localparam logic [4:0] ADM_RATIO_8  = 5'h08;

  typedef enum logic [1:0] {
    ADM_BOOT_SPI_SLAVE  = 2'b00,
    ADM_BOOT_SPI_MASTER = 2'b01,
    ADM_BOOT_PARALLEL   = 2'b10,
    ADM_BOOT_INT_ROM    = 2'b11
  } adm_boot_type;

  typedef enum logic [1:0] {
    ADM_CLK_3TO1    = 2'b00,
    ADM_CLK_16TO1   = 2'b01,
    ADM_CLK_8TO1    = 2'b10,
    ADM_CLK_RESERVD = 2'b11
  } adm_ratio_code_type;

  typedef enum logic [0:0] {
    ADM_WIDTH_8  = 1'b0,
    ADM_WIDTH_16 = 1'b1
  } adm_width_type;

  typedef enum logic [1:0] {
    ADM_ST_IDLE   = 2'b00,
    ADM_ST_ADDR   = 2'b01,
    ADM_ST_STROBE = 2'b10,
    ADM_ST_HOLD   = 2'b11
  } adm_state_type;

  typedef struct packed {
    logic                      write;
    logic [ADM_ADDR_WIDTH-1:0] addr;
    logic [ADM_AD_WIDTH-1:0]   wdata;
  } adm_req_type;

  typedef struct packed {
    logic [1:0] boot_sel;
    logic [1:0] clk_ratio;
  } adm_strap_type;

endpackage

// [rtl/adm_sync.sv]
module adm_sync
  import adm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule

// [rtl/adm_top.sv]
// Operation
// - Flag-use bit with port disabled gives flag pins
// - Pin bytes swap when mapped to flags
// - Boot straps choose one of four sources
// - Ratio straps pick 3, 16 or 8 multiplier
// - 8-bit address phase drives A15..8, A23..16
// - 8-bit data phase drives A7..0, carries D7..0 both ways
// - 16-bit address phase drives A15..0
// - 16-bit data phase carries D15..0 both ways
// - Read, write and latch strobes always driven
// - Wait 4096 reference cycles before starting
module adm_top
  import adm_pkg::*;
#(
  parameter int LOCK_REF_CYCLES = ADM_LOCK_REF_CYCLES
) (
  // Clock and reset
  input  wire logic                      MCLK,
  input  wire logic                      RST,
  // Configuration
  input  wire logic                      FLAG_USE,
  input  wire logic                      PORT_ENABLE,
  input  wire adm_width_type             PORT_WIDTH_MODE,
  // Access request and response
  input  wire logic                      REQ_VALID,
  input  wire adm_req_type               REQ,
  output logic                           REQ_READY,
  output logic                           RSP_VALID,
  output logic [ADM_AD_WIDTH-1:0]        RSP_RDATA,
  // Address/data pins
  input  wire logic [ADM_AD_WIDTH-1:0]   AD_IN,
  output logic      [ADM_AD_WIDTH-1:0]   AD_OUT,
  output logic      [ADM_AD_WIDTH-1:0]   AD_OE,
  output logic                           RD_N,
  output logic                           WR_N,
  output logic                           ALE,
  // General flags from and to the core
  input  wire logic [ADM_AD_WIDTH-1:0]   FLAG_OUT,
  input  wire logic [ADM_AD_WIDTH-1:0]   FLAG_OE,
  output logic      [ADM_AD_WIDTH-1:0]   FLAG_IN,
  // Straps and start-up status
  input  wire adm_strap_type             STRAPS,
  output adm_boot_type                   BOOT_MODE,
  output logic      [4:0]                CLK_RATIO,
  output logic                           RATIO_RESERVED,
  output logic                           CORE_READY
);

  localparam int LOCK_W = $clog2(LOCK_REF_CYCLES + 1);

  // Synchronised pins
  logic [ADM_AD_WIDTH-1:0] ad_sync;
  adm_strap_type           strap_sync;

  adm_sync #(.WIDTH(ADM_AD_WIDTH)) u_ad_sync (
    .clk (MCLK),
    .rst (RST),
    .d   (AD_IN),
    .q   (ad_sync)
  );

  adm_sync #(.WIDTH($bits(adm_strap_type))) u_strap_sync (
    .clk (MCLK),
    .rst (RST),
    .d   (STRAPS),
    .q   (strap_sync)
  );

  // Start-up: strap capture, reference tick divider, lock wait
  logic [1:0]        settle_cnt;
  logic              strap_taken;
  adm_boot_type      boot_mode;
  logic [4:0]        ratio;
  logic              ratio_rsvd;
  logic [4:0]        div_cnt;
  logic [LOCK_W-1:0] lock_cnt;
  logic              ready;
  logic [1:0]        next_settle_cnt;
  logic              next_strap_taken;
  adm_boot_type      next_boot_mode;
  logic [4:0]        next_ratio;
  logic              next_ratio_rsvd;
  logic [4:0]        next_div_cnt;
  logic [LOCK_W-1:0] next_lock_cnt;
  logic              next_ready;

  always_comb begin
    next_settle_cnt  = settle_cnt;
    next_strap_taken = strap_taken;
    next_boot_mode   = boot_mode;
    next_ratio       = ratio;
    next_ratio_rsvd  = ratio_rsvd;
    next_div_cnt     = div_cnt;
    next_lock_cnt    = lock_cnt;
    next_ready       = ready;
    if (!strap_taken) begin
      // Straps are taken once, after the synchroniser has filled past reset
      if (settle_cnt == ADM_STRAP_SETTLE) begin
        next_strap_taken = 1'b1;
        next_boot_mode   = adm_boot_type'(strap_sync.boot_sel);
        unique case (adm_ratio_code_type'(strap_sync.clk_ratio))
          ADM_CLK_3TO1:    next_ratio = ADM_RATIO_3;
          ADM_CLK_16TO1:   next_ratio = ADM_RATIO_16;
          ADM_CLK_8TO1:    next_ratio = ADM_RATIO_8;
          ADM_CLK_RESERVD: begin
            // Reserved code: run at the lowest ratio and report it
            next_ratio      = ADM_RATIO_3;
            next_ratio_rsvd = 1'b1;
          end
        endcase
      end else begin
        next_settle_cnt = settle_cnt + 2'h1;
      end
    end else if (!ready) begin
      // One reference clock period is ratio core cycles
      if (div_cnt == ratio - 5'h01) begin
        next_div_cnt = 5'h00;
        if (lock_cnt == LOCK_W'(LOCK_REF_CYCLES - 1)) begin
          next_ready = 1'b1;
        end else begin
          next_lock_cnt = lock_cnt + LOCK_W'(1);
        end
      end else begin
        next_div_cnt = div_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      settle_cnt  <= 2'h0;
      strap_taken <= 1'b0;
      boot_mode   <= ADM_BOOT_SPI_SLAVE;
      ratio       <= ADM_RATIO_3;
      ratio_rsvd  <= 1'b0;
      div_cnt     <= 5'h00;
      lock_cnt    <= '0;
      ready       <= 1'b0;
    end else begin
      settle_cnt  <= next_settle_cnt;
      strap_taken <= next_strap_taken;
      boot_mode   <= next_boot_mode;
      ratio       <= next_ratio;
      ratio_rsvd  <= next_ratio_rsvd;
      div_cnt     <= next_div_cnt;
      lock_cnt    <= next_lock_cnt;
      ready       <= next_ready;
    end
  end

  assign BOOT_MODE      = boot_mode;
  assign CLK_RATIO      = ratio;
  assign RATIO_RESERVED = ratio_rsvd;
  assign CORE_READY     = ready;

  // Pin function select
  logic flag_mode;
  assign flag_mode = FLAG_USE && !PORT_ENABLE;

  // Parallel port cycle engine
  adm_state_type           state;
  logic [3:0]              phase_cnt;
  adm_req_type             req;
  adm_width_type           width;
  logic [ADM_AD_WIDTH-1:0] bus_out;
  logic [ADM_AD_WIDTH-1:0] bus_oe;
  logic                    rd_n;
  logic                    wr_n;
  logic                    ale;
  logic                    rsp_valid;
  logic [ADM_AD_WIDTH-1:0] rsp_rdata;
  adm_state_type           next_state;
  logic [3:0]              next_phase_cnt;
  adm_req_type             next_req;
  adm_width_type           next_width;
  logic [ADM_AD_WIDTH-1:0] next_bus_out;
  logic [ADM_AD_WIDTH-1:0] next_bus_oe;
  logic                    next_rd_n;
  logic                    next_wr_n;
  logic                    next_ale;
  logic                    next_rsp_valid;
  logic [ADM_AD_WIDTH-1:0] next_rsp_rdata;

  // Width mode may change only between cycles; it is held per access
  assign REQ_READY = (state == ADM_ST_IDLE) && ready && PORT_ENABLE && !flag_mode;

  always_comb begin
    next_state     = state;
    next_phase_cnt = phase_cnt;
    next_req       = req;
    next_width     = width;
    next_bus_out   = bus_out;
    next_bus_oe    = bus_oe;
    next_rd_n      = 1'b1;
    next_wr_n      = 1'b1;
    next_ale       = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    unique case (state)
      ADM_ST_IDLE: begin
        next_bus_oe = '0;
        if (REQ_VALID && REQ_READY) begin
          next_req       = REQ;
          next_width     = PORT_WIDTH_MODE;
          next_state     = ADM_ST_ADDR;
          next_phase_cnt = 4'h0;
          next_ale       = 1'b1;
          next_bus_oe    = '1;
          if (PORT_WIDTH_MODE == ADM_WIDTH_8) begin
            next_bus_out = {REQ.addr[23:16], REQ.addr[15:8]};
          end else begin
            next_bus_out = REQ.addr[15:0];
          end
        end
      end
      ADM_ST_ADDR: begin
        if (phase_cnt == ADM_ADDR_CYCLES - 4'h1) begin
          next_state     = ADM_ST_STROBE;
          next_phase_cnt = 4'h0;
          next_rd_n      = req.write;
          next_wr_n      = !req.write;
          if (width == ADM_WIDTH_8) begin
            next_bus_out = {req.addr[7:0], req.wdata[7:0]};
            next_bus_oe  = {8'hFF, {8{req.write}}};
          end else begin
            next_bus_out = req.wdata;
            next_bus_oe  = {ADM_AD_WIDTH{req.write}};
          end
        end else begin
          next_ale       = 1'b1;
          next_phase_cnt = phase_cnt + 4'h1;
        end
      end
      ADM_ST_STROBE: begin
        if (phase_cnt == ADM_STROBE_CYCLES - 4'h1) begin
          // Read data is sampled through the pin synchroniser at strobe end
          next_state     = ADM_ST_HOLD;
          next_phase_cnt = 4'h0;
          if (!req.write) begin
            next_rsp_valid = 1'b1;
            if (width == ADM_WIDTH_8) begin
              next_rsp_rdata = {8'h00, ad_sync[7:0]};
            end else begin
              next_rsp_rdata = ad_sync;
            end
          end
        end else begin
          next_rd_n      = req.write;
          next_wr_n      = !req.write;
          next_phase_cnt = phase_cnt + 4'h1;
        end
      end
      ADM_ST_HOLD: begin
        // Write data stays a cycle past the strobe for the memory's hold time
        if (phase_cnt == ADM_HOLD_CYCLES - 4'h1) begin
          next_state  = ADM_ST_IDLE;
          next_bus_oe = '0;
        end else begin
          next_phase_cnt = phase_cnt + 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state     <= ADM_ST_IDLE;
      phase_cnt <= 4'h0;
      req       <= '0;
      width     <= ADM_WIDTH_8;
      bus_out   <= '0;
      bus_oe    <= '0;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      ale       <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      state     <= next_state;
      phase_cnt <= next_phase_cnt;
      req       <= next_req;
      width     <= next_width;
      bus_out   <= next_bus_out;
      bus_oe    <= next_bus_oe;
      rd_n      <= next_rd_n;
      wr_n      <= next_wr_n;
      ale       <= next_ale;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
    end
  end

  assign RSP_VALID = rsp_valid;
  assign RSP_RDATA = rsp_rdata;
  assign RD_N      = rd_n;
  assign WR_N      = wr_n;
  assign ALE       = ale;

  // Flag redirection; a cycle in flight loses the AD pins but its strobes run on if flag use is forced
  logic [ADM_AD_WIDTH-1:0] flag_pin_out;
  logic [ADM_AD_WIDTH-1:0] flag_pin_oe;
  logic [ADM_AD_WIDTH-1:0] next_flag_pin_out;
  logic [ADM_AD_WIDTH-1:0] next_flag_pin_oe;

  always_comb begin
    next_flag_pin_out = {FLAG_OUT[7:0], FLAG_OUT[15:8]};
    next_flag_pin_oe  = '0;
    if (flag_mode) begin
      next_flag_pin_oe = {FLAG_OE[7:0], FLAG_OE[15:8]};
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flag_pin_out <= '0;
      flag_pin_oe  <= '0;
    end else begin
      flag_pin_out <= next_flag_pin_out;
      flag_pin_oe  <= next_flag_pin_oe;
    end
  end

  assign AD_OUT  = flag_mode ? flag_pin_out : bus_out;
  assign AD_OE   = flag_mode ? flag_pin_oe : bus_oe;
  assign FLAG_IN = {ad_sync[7:0], ad_sync[15:8]};

endmodule

// [bench/adm_checker.sv]
module adm_checker
  import adm_pkg::*;
#(
  parameter int LOCK_REF_CYCLES = ADM_LOCK_REF_CYCLES
) (
  // Clock and reset
  input wire logic          MCLK,
  input wire logic          RST,
  // Configuration and requests
  input wire logic          FLAG_USE,
  input wire logic          PORT_ENABLE,
  input wire adm_width_type PORT_WIDTH_MODE,
  input wire logic          REQ_VALID,
  input wire adm_req_type   REQ,
  input wire logic          REQ_READY,
  input wire logic          RSP_VALID,
  // Pins and flags
  input wire logic [15:0]   AD_IN,
  input wire logic [15:0]   AD_OUT,
  input wire logic [15:0]   AD_OE,
  input wire logic          RD_N,
  input wire logic          WR_N,
  input wire logic          ALE,
  input wire logic [15:0]   FLAG_OUT,
  input wire logic [15:0]   FLAG_OE,
  input wire logic [15:0]   FLAG_IN,
  // Start-up status
  input wire logic [4:0]    CLK_RATIO,
  input wire logic          CORE_READY
);
  timeunit 1ns;
  timeprecision 100ps;
  logic          fm;
  adm_req_type   cap;
  adm_width_type wid;
  logic [19:0]   cnt;
  int            lock_n;
  assign fm = FLAG_USE & !PORT_ENABLE;
  // Wait adds the three cycles of strap settle and capture
  assign lock_n = LOCK_REF_CYCLES * int'(CLK_RATIO) + 3;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cap <= '0;
      wid <= ADM_WIDTH_8;
      cnt <= '0;
    end else begin
      if (REQ_VALID && REQ_READY) begin
        cap <= REQ;
        wid <= PORT_WIDTH_MODE;
      end
      if (cnt != 20'hFFFFF) cnt <= cnt + 20'h00001;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  flag_pins_a:
    assert property (fm && $past(fm) && !$past(RST) |-> AD_OUT == {$past(FLAG_OUT[7:0]),
      $past(FLAG_OUT[15:8])} && AD_OE == {$past(FLAG_OE[7:0]), $past(FLAG_OE[15:8])})
      else $error("flag drive not byte swapped");
  flag_sense_a:
    assert property (fm && $past(fm) && $past(fm, 2) && !$past(RST) && !$past(RST, 2) |->
      FLAG_IN == {$past(AD_IN[7:0], 2), $past(AD_IN[15:8], 2)}) else $error("flag sense wrong");
  idle_quiet_a:
    assert property (!fm && REQ_READY |-> AD_OE == 16'h0000) else $error("pins driven idle");
  ale_len_a:
    assert property ($rose(ALE) |-> ALE [*2] ##1 !ALE ##0 (!RD_N || !WR_N))
      else $error("latch strobe length wrong");
  rd_len_a:
    assert property ($fell(RD_N) |-> !RD_N [*4] ##1 RD_N && RSP_VALID)
      else $error("read strobe or answer wrong");
  wr_len_a:
    assert property ($fell(WR_N) |-> !WR_N [*4] ##1 WR_N && !RSP_VALID ##1 AD_OE == 16'h0000)
      else $error("write strobe or release wrong");
  addr_phase_a:
    assert property (ALE && !fm |-> AD_OE == 16'hFFFF &&
      AD_OUT == (wid == ADM_WIDTH_16 ? cap.addr[15:0] : cap.addr[23:8]))
      else $error("address phase wrong");
  wr_data_a:
    assert property (!WR_N && !fm |-> AD_OE == 16'hFFFF &&
      AD_OUT == (wid == ADM_WIDTH_16 ? cap.wdata : {cap.addr[7:0], cap.wdata[7:0]}))
      else $error("write data phase wrong");
  rd_phase_a:
    assert property (!RD_N && !fm |-> AD_OE == (wid == ADM_WIDTH_16 ? 16'h0000 : 16'hFF00)
      && (wid == ADM_WIDTH_16 || AD_OUT[15:8] == cap.addr[7:0])) else $error("read phase wrong");
  lock_early_a:
    assert property (cnt + 2 < lock_n |-> !CORE_READY) else $error("core ready too early");
  lock_late_a:
    assert property (cnt > lock_n + 2 |-> CORE_READY) else $error("core ready too late");
endmodule

bind adm_top adm_checker #(.LOCK_REF_CYCLES(LOCK_REF_CYCLES)) u_chk (.MCLK, .RST, .FLAG_USE,
  .PORT_ENABLE, .PORT_WIDTH_MODE, .REQ_VALID, .REQ, .REQ_READY, .RSP_VALID, .AD_IN, .AD_OUT,
  .AD_OE, .RD_N, .WR_N, .ALE, .FLAG_OUT, .FLAG_OE, .FLAG_IN, .CLK_RATIO, .CORE_READY);

// [bench/adm_mem_model.sv]
module adm_mem_model
  import adm_pkg::*;
(
  // Clock and strobes
  input  wire logic        clk,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        byte_mode,
  // Pin level and drive
  input  wire logic [15:0] ad,
  output logic      [15:0] drv,
  output logic      [15:0] oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [16];
  logic [15:0] latch_q;
  always_ff @(posedge clk) begin
    if (ale) latch_q <= ad;
    if (!wr_n) mem[latch_q[3:0]] <= byte_mode ? {8'h00, ad[7:0]} : ad;
  end
  // Narrow reads leave the high byte to the device's late address
  assign oe  = rd_n ? 16'h0000 : (byte_mode ? 16'h00FF : 16'hFFFF);
  assign drv = mem[latch_q[3:0]];
endmodule

// [bench/tb_top.sv]
module tb_top
  import adm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clk, rst, flag_use, port_en, req_valid, req_ready, rsp_valid;
  logic          rd_n, wr_n, ale, ratio_res, core_ready;
  logic [15:0]   ad_wire, ad_out, ad_oe, mem_drv, mem_oe, flag_out, flag_oe, flag_in, rdata;
  logic [4:0]    ratio;
  adm_width_type width;
  adm_req_type   req;
  adm_strap_type straps;
  adm_boot_type  boot;
  int            err_count, n_checks;
  logic [4:0]    exp_ratio [4] = '{ADM_RATIO_3, ADM_RATIO_16, ADM_RATIO_8, ADM_RATIO_3};
  // Undriven lines rise through the pin pull-ups
  assign ad_wire = (ad_oe & ad_out) | (mem_oe & mem_drv) | ~(ad_oe | mem_oe);
  adm_top #(.LOCK_REF_CYCLES(4)) u_dut (.MCLK(clk), .RST(rst), .FLAG_USE(flag_use),
    .PORT_ENABLE(port_en), .PORT_WIDTH_MODE(width), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rdata), .AD_IN(ad_wire),
    .AD_OUT(ad_out), .AD_OE(ad_oe), .RD_N(rd_n), .WR_N(wr_n), .ALE(ale),
    .FLAG_OUT(flag_out), .FLAG_OE(flag_oe), .FLAG_IN(flag_in), .STRAPS(straps),
    .BOOT_MODE(boot), .CLK_RATIO(ratio), .RATIO_RESERVED(ratio_res), .CORE_READY(core_ready));
  adm_mem_model u_mem (.clk(clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .byte_mode(width == ADM_WIDTH_8), .ad(ad_wire), .drv(mem_drv), .oe(mem_oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] code);
    int i;
    @(posedge clk);
    straps <= '{boot_sel: code, clk_ratio: code};
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    chk("strobes in reset", {rd_n, wr_n, ale, ad_oe}, 19'h60000);
    rst <= 1'b0;
    for (i = 0; i < 500 && core_ready !== 1'b1; i++) @(negedge clk);
    chk("core ready", core_ready, 1);
  endtask
  task automatic access(input logic wr, input adm_width_type w, input logic [23:0] a,
                        input logic [15:0] wd, input logic [15:0] exp);
    int i;
    @(posedge clk);
    width <= w;
    req <= '{write: wr, addr: a, wdata: wd};
    req_valid <= 1'b1;
    @(negedge clk);
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk);
    chk("request ready", req_ready, 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    for (i = 0; i < 20 && rsp_valid !== 1'b1 && req_ready !== 1'b1; i++) @(negedge clk);
    // A write has no answer, so its completion is seen as ready returning
    chk("access done", wr ? req_ready : rsp_valid, 1'b1);
    if (!wr) chk("read data", rdata, exp);
  endtask
  initial begin
    int c;
    rst = 1'b1;
    flag_use = 1'b0;
    port_en = 1'b1;
    req_valid = 1'b0;
    width = ADM_WIDTH_16;
    req = '0;
    straps = '0;
    flag_out = '0;
    flag_oe = '0;
    err_count = 0;
    n_checks = 0;
    for (c = 3; c >= 0; c--) begin
      do_reset(c[1:0]);
      chk("boot mode", boot, c);
      chk("clock ratio", ratio, exp_ratio[c]);
      chk("ratio reserved", ratio_res, c == 3);
    end
    $display("straps test done");
    access(1'b1, ADM_WIDTH_16, 24'h000005, 16'hA5C3, 16'h0000);
    access(1'b1, ADM_WIDTH_16, 24'h000006, 16'h3C5A, 16'h0000);
    access(1'b0, ADM_WIDTH_16, 24'h000005, 16'h0000, 16'hA5C3);
    access(1'b0, ADM_WIDTH_8, 24'h000600, 16'h0000, 16'h005A);
    access(1'b1, ADM_WIDTH_8, 24'h000799, 16'h0042, 16'h0000);
    access(1'b0, ADM_WIDTH_16, 24'h000007, 16'h0000, 16'h0042);
    $display("port test done");
    @(posedge clk);
    flag_use <= 1'b1;
    flag_out <= 16'h12AB;
    flag_oe <= 16'hFFFF;
    repeat (3) @(negedge clk);
    chk("ready port on", req_ready, 1);
    chk("pins port on", ad_oe, 16'h0000);
    @(posedge clk);
    port_en <= 1'b0;
    repeat (4) @(negedge clk);
    chk("ready flag use", req_ready, 0);
    chk("flag drive", {ad_oe, ad_out[7:0]}, 24'hFFFF12);
    chk("flag sense", flag_in, 16'h12AB);
    @(posedge clk);
    flag_oe <= 16'h00F0;
    repeat (4) @(negedge clk);
    chk("flag enable", ad_oe, 16'hF000);
    chk("flag partial", flag_in, 16'hFFAF);
    @(posedge clk);
    flag_use <= 1'b0;
    port_en <= 1'b1;
    $display("flag test done");
    end_of_test();
  end
  initial begin
    #20000;
    err_count++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
